// >>> logic/cdl_pkg.sv
// Package with register map, field positions and types of the receive front end
package cdl_pkg;

   localparam int unsigned  ADDR_W        = 8;
   localparam int unsigned  DATA_W        = 32;
   localparam int unsigned  WORD_MAX      = 10;
   localparam int unsigned  CNT_W         = 4;
   localparam int unsigned  BITS_PER_CLK  = 2;
   localparam int unsigned  IRQ_W         = 3;

   localparam int unsigned  CLK_HZ        = 50_000_000;
   localparam int unsigned  CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

   localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_WORD     = 8'h10;

   localparam int unsigned  CTRL_CODEC_EN  = 0;
   localparam int unsigned  CTRL_PIPE_MODE = 1;
   localparam int unsigned  CTRL_MANUAL_EN = 2;
   localparam int unsigned  CTRL_WIDTH10   = 3;
   localparam int unsigned  CTRL_DESER_EN  = 4;
   localparam int unsigned  CTRL_W         = 5;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h11;

   localparam int unsigned  ST_ACTIVITY   = 0;
   localparam int unsigned  ST_LOCKED     = 1;
   localparam int unsigned  ST_DATA_TRACK = 2;

   localparam int unsigned  IRQ_LOCK_GAIN = 0;
   localparam int unsigned  IRQ_LOCK_LOSS = 1;
   localparam int unsigned  IRQ_ACT_CHG   = 2;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

   localparam logic [CNT_W-1:0] WIDTH_8  = 4'h8;
   localparam logic [CNT_W-1:0] WIDTH_10 = 4'hA;

   typedef enum logic {
      CDL_REFERENCE_TRACKING_STATE = 1'b0,
      CDL_DATA_TRACKING_STATE      = 1'b1
   } cdl_cdr_state_t;

   typedef struct packed {
      logic                psel;
      logic                penable;
      logic                pwrite;
      logic [ADDR_W-1:0]   paddr;
      logic [DATA_W-1:0]   pwdata;
   } cdl_apb_req_t;

   typedef struct packed {
      logic                pready;
      logic [DATA_W-1:0]   prdata;
      logic                pslverr;
   } cdl_apb_rsp_t;

endpackage : cdl_pkg

// >>> logic/cdl_rx_front.sv
// Receive front end: signal detect, clock recovery lock control, deserializer, APB registers
//
// Summary of operation
// - Line activity output follows the threshold detector's valid-signal indication.
// - Without the line code enabled, line activity is held high constantly.
// - Deserializer runs on the fast recovered clock domain, words go to coding logic.
// - Reference tracking disables phase detector; data tracking enables it.
// - Reset places clock recovery in reference tracking.
// - Automatic mode enters data tracking when frequency in range and detect met.
// - Automatic mode leaves data tracking on frequency out of range or detect lost.
// - Signal detect joins automatic transitions only in PIPE mode.
// - Automatic mode lock indicator rises entering and falls leaving data tracking.
// - Manual mode state follows the force-reference and force-data input levels.
// - Manual mode lock indicator is high exactly in data tracking.
// - With manual inputs not enabled, the controller runs in automatic mode.
// - Deserializer builds parallel words of 8 or 10 bits.
// - First received bit of a word is its least significant bit.
// - Two bits are captured per fast clock, one per clock edge; here both come in on a two-bit input sampled at the rising edge.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/100ps

module cdl_rx_front #(
   parameter int unsigned WORD_W = cdl_pkg::WORD_MAX
) (
   input  wire logic                               clk,
   input  wire logic                               resetn,
   input  wire logic                               ce,
   input  wire cdl_pkg::cdl_apb_req_t              apb_req,
   output      cdl_pkg::cdl_apb_rsp_t              apb_rsp,
   input  wire logic                               signal_level_ok,
   input  wire logic                               ppm_in_range,
   input  wire logic                               force_ref_lock,
   input  wire logic                               force_data_lock,
   input  wire logic [cdl_pkg::BITS_PER_CLK-1:0]   serial_bits,
   output      logic                               line_activity,
   output      logic                               freq_locked,
   output      logic                               phase_det_en,
   output      logic [WORD_W-1:0]                  rx_word,
   output      logic                               rx_word_valid,
   output      logic                               irq
);

   typedef struct packed {
      cdl_pkg::cdl_apb_rsp_t         rsp;
      logic [cdl_pkg::CTRL_W-1:0]    ctrl;
      logic [cdl_pkg::IRQ_W-1:0]     irq_stat;
      logic [cdl_pkg::IRQ_W-1:0]     irq_mask;
      cdl_pkg::cdl_cdr_state_t       cdr;
      logic                          activity;
      logic                          locked;
      logic                          pd_en;
      logic [WORD_W-1:0]             shift;
      logic [cdl_pkg::CNT_W-1:0]     cnt;
      logic [WORD_W-1:0]             word;
      logic                          word_valid;
      logic                          irq;
   } cdl_state_t;

   cdl_state_t state;
   cdl_state_t next_state;

   function automatic logic cdl_hit(
      input logic [cdl_pkg::ADDR_W-1:0] addr,
      input logic [cdl_pkg::ADDR_W-1:0] off
   );
      cdl_hit = (addr == off);
   endfunction : cdl_hit

   function automatic logic cdl_mapped(
      input logic [cdl_pkg::ADDR_W-1:0] addr
   );
      cdl_mapped = cdl_hit(addr, cdl_pkg::OFF_CTRL)
                 | cdl_hit(addr, cdl_pkg::OFF_STATUS)
                 | cdl_hit(addr, cdl_pkg::OFF_IRQ_STAT)
                 | cdl_hit(addr, cdl_pkg::OFF_IRQ_MASK)
                 | cdl_hit(addr, cdl_pkg::OFF_WORD);
   endfunction : cdl_mapped

   logic                         setup_done;
   logic                         commit;
   logic                         wr_commit;
   logic                         stat_read;
   logic                         codec_en;
   logic                         pipe_mode;
   logic                         manual_en;
   logic                         next_activity;
   logic                         sd_ok;
   logic                         width10;
   logic [cdl_pkg::CNT_W-1:0]    width;
   logic [cdl_pkg::CNT_W-1:0]    cnt_next;
   logic [WORD_W-1:0]            shift_acc;
   logic [cdl_pkg::IRQ_W-1:0]    events;
   logic [cdl_pkg::DATA_W-1:0]   rdata;

   always_comb begin
      next_state = state;
      codec_en   = state.ctrl[cdl_pkg::CTRL_CODEC_EN];
      pipe_mode  = state.ctrl[cdl_pkg::CTRL_PIPE_MODE];
      manual_en  = state.ctrl[cdl_pkg::CTRL_MANUAL_EN];
      width10    = state.ctrl[cdl_pkg::CTRL_WIDTH10];
      width      = width10 ? cdl_pkg::WIDTH_10 : cdl_pkg::WIDTH_8;
      events     = '0;
      rdata      = '0;
      shift_acc  = state.shift;
      cnt_next   = state.cnt;

      // Bus access phase; one wait state, commit on the pready edge
      setup_done = apb_req.psel & apb_req.penable & ~state.rsp.pready;
      commit     = apb_req.psel & apb_req.penable & state.rsp.pready;
      wr_commit  = commit & apb_req.pwrite & ~state.rsp.pslverr;
      stat_read  = commit & ~apb_req.pwrite
                 & cdl_hit(apb_req.paddr, cdl_pkg::OFF_IRQ_STAT);

      // Signal detect qualifier
      if (codec_en) begin
         next_activity = signal_level_ok;
      end else begin
         next_activity = 1'b1;
      end
      next_state.activity = next_activity;

      // Detect condition counts only in PIPE mode
      sd_ok = pipe_mode ? next_activity : 1'b1;

      // Lock controller
      if (manual_en) begin
         if (force_ref_lock) begin
            next_state.cdr = cdl_pkg::CDL_REFERENCE_TRACKING_STATE;
         end else if (force_data_lock) begin
            next_state.cdr = cdl_pkg::CDL_DATA_TRACKING_STATE;
         end else begin
            next_state.cdr = cdl_pkg::CDL_REFERENCE_TRACKING_STATE;
         end
      end else begin
         case (state.cdr)
            cdl_pkg::CDL_REFERENCE_TRACKING_STATE: begin
               if (ppm_in_range && sd_ok) begin
                  next_state.cdr = cdl_pkg::CDL_DATA_TRACKING_STATE;
               end
            end
            cdl_pkg::CDL_DATA_TRACKING_STATE: begin
               if (!ppm_in_range || !sd_ok) begin
                  next_state.cdr = cdl_pkg::CDL_REFERENCE_TRACKING_STATE;
               end
            end
            default: begin
               next_state.cdr = cdl_pkg::CDL_REFERENCE_TRACKING_STATE;
            end
         endcase
      end

      // Lock indicator and phase detector follow the state
      next_state.locked = (next_state.cdr == cdl_pkg::CDL_DATA_TRACKING_STATE);
      next_state.pd_en  = (next_state.cdr == cdl_pkg::CDL_DATA_TRACKING_STATE);

      events[cdl_pkg::IRQ_LOCK_GAIN] = next_state.locked & ~state.locked;
      events[cdl_pkg::IRQ_LOCK_LOSS] = ~next_state.locked & state.locked;
      events[cdl_pkg::IRQ_ACT_CHG]   = next_activity ^ state.activity;

      // Deserializer: two bits per clock, earlier bit into lower position
      next_state.word_valid = 1'b0;
      if (state.ctrl[cdl_pkg::CTRL_DESER_EN]) begin
         for (int i = 0; i < int'(cdl_pkg::BITS_PER_CLK); i++) begin
            shift_acc[cdl_pkg::CNT_W'(state.cnt + cdl_pkg::CNT_W'(i))] =
               serial_bits[i];
         end
         cnt_next = cdl_pkg::CNT_W'(state.cnt + cdl_pkg::CNT_W'(cdl_pkg::BITS_PER_CLK));
         if (cnt_next >= width) begin
            next_state.word       = shift_acc;
            next_state.word_valid = 1'b1;
            next_state.shift      = '0;
            next_state.cnt        = '0;
         end else begin
            next_state.shift      = shift_acc;
            next_state.cnt        = cnt_next;
         end
         if (!width10) begin
            next_state.word[WORD_W-1:cdl_pkg::WIDTH_8] = '0;
         end
      end else begin
         next_state.shift = '0;
         next_state.cnt   = '0;
      end

      // Read data mux
      if (cdl_hit(apb_req.paddr, cdl_pkg::OFF_CTRL)) begin
         rdata[cdl_pkg::CTRL_W-1:0] = state.ctrl;
      end else if (cdl_hit(apb_req.paddr, cdl_pkg::OFF_STATUS)) begin
         rdata[cdl_pkg::ST_ACTIVITY]   = state.activity;
         rdata[cdl_pkg::ST_LOCKED]     = state.locked;
         rdata[cdl_pkg::ST_DATA_TRACK] = state.cdr;
      end else if (cdl_hit(apb_req.paddr, cdl_pkg::OFF_IRQ_STAT)) begin
         rdata[cdl_pkg::IRQ_W-1:0] = state.irq_stat;
      end else if (cdl_hit(apb_req.paddr, cdl_pkg::OFF_IRQ_MASK)) begin
         rdata[cdl_pkg::IRQ_W-1:0] = state.irq_mask;
      end else if (cdl_hit(apb_req.paddr, cdl_pkg::OFF_WORD)) begin
         rdata[WORD_W-1:0] = state.word;
      end

      // Bus response
      if (setup_done) begin
         next_state.rsp.pready  = 1'b1;
         next_state.rsp.pslverr = ~cdl_mapped(apb_req.paddr);
         next_state.rsp.prdata  = apb_req.pwrite ? '0 : rdata;
      end else begin
         next_state.rsp.pready  = 1'b0;
         next_state.rsp.pslverr = 1'b0;
      end

      // Register writes
      if (wr_commit && cdl_hit(apb_req.paddr, cdl_pkg::OFF_CTRL)) begin
         next_state.ctrl = apb_req.pwdata[cdl_pkg::CTRL_W-1:0];
      end
      if (wr_commit && cdl_hit(apb_req.paddr, cdl_pkg::OFF_IRQ_MASK)) begin
         next_state.irq_mask = apb_req.pwdata[cdl_pkg::IRQ_W-1:0];
      end

      // Sticky status, read clears only the bits reported, new event wins
      next_state.irq_stat = (stat_read ? (state.irq_stat & ~state.rsp.prdata[cdl_pkg::IRQ_W-1:0])
                                       : state.irq_stat) | events;
      next_state.irq      = |(next_state.irq_stat & next_state.irq_mask);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state.rsp.pready  <= 1'b0;
         state.rsp.prdata  <= '0;
         state.rsp.pslverr <= 1'b0;
         state.ctrl        <= cdl_pkg::CTRL_RESET;
         state.irq_stat    <= '0;
         state.irq_mask    <= cdl_pkg::IRQ_MASK_RESET;
         state.cdr         <= cdl_pkg::CDL_REFERENCE_TRACKING_STATE;
         state.activity    <= 1'b1;
         state.locked      <= 1'b0;
         state.pd_en       <= 1'b0;
         state.shift       <= '0;
         state.cnt         <= '0;
         state.word        <= '0;
         state.word_valid  <= 1'b0;
         state.irq         <= 1'b0;
      end else if (ce) begin
         state <= next_state;
      end
   end

   assign apb_rsp       = state.rsp;
   assign line_activity = state.activity;
   assign freq_locked   = state.locked;
   assign phase_det_en  = state.pd_en;
   assign rx_word       = state.word;
   assign rx_word_valid = state.word_valid;
   assign irq           = state.irq;

endmodule : cdl_rx_front

// >>> tb/cdl_rx_front_checker.sv
// Port assertions for the receive front end
`timescale 1ns/100ps
module cdl_rx_front_checker (
   input wire logic                  clk,
   input wire logic                  resetn,
   input wire logic                  ce,
   input wire cdl_pkg::cdl_apb_req_t apb_req,
   input wire cdl_pkg::cdl_apb_rsp_t apb_rsp,
   input wire logic                  signal_level_ok,
   input wire logic                  ppm_in_range,
   input wire logic                  force_ref_lock,
   input wire logic                  force_data_lock,
   input wire logic                  line_activity,
   input wire logic                  freq_locked,
   input wire logic                  phase_det_en,
   input wire logic                  rx_word_valid
);
   logic [4:0] ctl;
   logic       man;
   logic       pipe;
   // Shadow of the control register, taken at each completed write
   always_ff @(posedge clk or negedge resetn)
      if (!resetn) ctl <= cdl_pkg::CTRL_RESET;
      else if (ce && apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready
               && apb_req.paddr == cdl_pkg::OFF_CTRL) ctl <= apb_req.pwdata[4:0];
   assign man  = ctl[2];
   assign pipe = ctl[1] & ctl[0];
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn || !ce);
   sequence s_locked; freq_locked && phase_det_en; endsequence
   a_phase_tie: assert property (phase_det_en == freq_locked)
      else $error("phase detector enable differs from lock");
   a_reset_ref: assert property ($rose(resetn) |-> !freq_locked)
      else $error("lock set right after reset");
   a_auto_gain: assert property (!man && ppm_in_range && (!pipe || signal_level_ok) |=> s_locked)
      else $error("automatic lock not gained");
   a_auto_loss: assert property (!man && (!ppm_in_range || pipe && !signal_level_ok) |=> !freq_locked)
      else $error("automatic lock not dropped");
   a_manual_ref: assert property (man && (force_ref_lock || !force_data_lock) |=> !freq_locked)
      else $error("manual reference tracking not taken");
   a_manual_data: assert property (man && !force_ref_lock && force_data_lock |=> s_locked)
      else $error("manual data tracking not taken");
   a_act_follow: assert property (ctl[0] |=> line_activity == $past(signal_level_ok))
      else $error("line activity does not follow detector");
   a_act_forced: assert property (!ctl[0] |=> line_activity)
      else $error("line activity not held high");
   a_valid_pulse: assert property (rx_word_valid |=> !rx_word_valid [*3])
      else $error("words closer than four clocks");
endmodule : cdl_rx_front_checker
bind cdl_rx_front cdl_rx_front_checker i_chk (.clk, .resetn, .ce, .apb_req, .apb_rsp,
   .signal_level_ok, .ppm_in_range, .force_ref_lock, .force_data_lock, .line_activity,
   .freq_locked, .phase_det_en, .rx_word_valid);

// >>> tb/cdl_remote_tx.sv
// Remote serial transmitter model, two bits per clock
`timescale 1ns/100ps
module cdl_remote_tx (
   input  wire logic       clk,
   output      logic [1:0] serial_bits
);
   initial serial_bits = 2'h2;
   task automatic send(input logic [9:0] a, input logic [9:0] b, input int n);
      logic [9:0] w;
      for (int j = 0; j < 2; j++) begin
         w = j ? b : a;
         for (int i = 0; i < n; i += 2) begin
            serial_bits <= {w[i+1], w[i]};
            @(posedge clk);
         end
      end
      serial_bits <= ~serial_bits;
   endtask : send
endmodule : cdl_remote_tx

// >>> tb/cdl_rx_front_tb.sv
// Self-checking bench for the receive front end
`timescale 1ns/100ps
module cdl_rx_front_tb;
   logic                  clk, resetn, sig, ppm, fr, fd, vld, locked, ph, act, irq, serr, ce;
   logic [1:0]            bits;
   logic [9:0]            word;
   logic [31:0]           rd;
   int                    err_total, checks, cyc;
   cdl_pkg::cdl_apb_req_t req;
   cdl_pkg::cdl_apb_rsp_t rsp;
   cdl_rx_front i_dut (.clk, .resetn, .ce, .apb_req(req), .apb_rsp(rsp),
      .signal_level_ok(sig), .ppm_in_range(ppm), .force_ref_lock(fr), .force_data_lock(fd),
      .serial_bits(bits), .line_activity(act), .freq_locked(locked), .phase_det_en(ph),
      .rx_word(word), .rx_word_valid(vld), .irq);
   cdl_remote_tx i_tx (.clk, .serial_bits(bits));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      serr = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb
   task automatic wait2;
      repeat (2) @(posedge clk);
   endtask : wait2
   task automatic t_reset;
      chk(locked, 1'b0, "lock");
      apb(1'b0, cdl_pkg::OFF_CTRL, 32'h0);
      chk(rd, 32'h11, "ctrl");
      apb(1'b0, cdl_pkg::OFF_IRQ_MASK, 32'h0);
      chk(rd, 32'h0, "mask");
      apb(1'b0, 8'h20, 32'h0);
      chk(serr, 1'b1, "unmapped");
   endtask : t_reset
   task automatic t_auto;
      apb(1'b1, cdl_pkg::OFF_IRQ_MASK, 32'h1);
      apb(1'b0, cdl_pkg::OFF_IRQ_STAT, 32'h0);
      ppm <= 1'b1;
      wait2;
      chk(locked, 1'b1, "lock");
      chk(ph, 1'b1, "phase");
      chk(irq, 1'b1, "irq");
      apb(1'b0, cdl_pkg::OFF_STATUS, 32'h0);
      chk(rd, 32'h6, "status");
      ppm <= 1'b0;
      wait2;
      chk(locked, 1'b0, "unlock");
      apb(1'b0, cdl_pkg::OFF_IRQ_STAT, 32'h0);
      chk(rd, 32'h3, "irq_stat");
      wait2;
      chk(irq, 1'b0, "irq_clear");
   endtask : t_auto
   task automatic t_freeze;
      ce <= 1'b0;
      ppm <= 1'b1;
      wait2;
      chk(locked, 1'b0, "frozen");
      ce <= 1'b1;
      wait2;
      chk(locked, 1'b1, "thawed");
      ppm <= 1'b0;
      wait2;
   endtask : t_freeze
   task automatic t_pipe;
      apb(1'b1, cdl_pkg::OFF_CTRL, 32'h13);
      ppm <= 1'b1;
      wait2;
      chk(locked, 1'b0, "pipe_nosig");
      sig <= 1'b1;
      wait2;
      chk(locked, 1'b1, "pipe_lock");
      chk(act, 1'b1, "act_on");
      sig <= 1'b0;
      wait2;
      chk(locked, 1'b0, "pipe_loss");
      chk(act, 1'b0, "act_off");
      apb(1'b1, cdl_pkg::OFF_CTRL, 32'h12);
      wait2;
      chk(act, 1'b1, "act_forced");
   endtask : t_pipe
   task automatic t_manual;
      apb(1'b1, cdl_pkg::OFF_CTRL, 32'h15);
      ppm <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         {fr, fd} <= i[1:0];
         wait2;
         chk(locked, i == 1, "manual");
      end
      {fr, fd} <= 2'h1;
      apb(1'b1, cdl_pkg::OFF_CTRL, 32'h11);
      wait2;
      chk(locked, 1'b0, "auto_again");
   endtask : t_manual
   task automatic t_deser;
      logic [9:0] w [2] = '{10'h3A5, 10'h15A};
      for (int n = 8; n <= 10; n += 2) begin
         apb(1'b1, cdl_pkg::OFF_CTRL, 32'h01);
         apb(1'b1, cdl_pkg::OFF_CTRL, (n == 10) ? 32'h19 : 32'h11);
         fork
            i_tx.send(w[0], w[1], n);
            for (int k = 0; k < 2; k++) begin
               repeat (n / 2) @(posedge clk);
               #1;
               chk(vld, 1'b1, "valid");
               chk(word, w[k] & ((n == 10) ? 10'h3FF : 10'h0FF), "word");
            end
         join
      end
      apb(1'b1, cdl_pkg::OFF_CTRL, 32'h09);
      apb(1'b0, cdl_pkg::OFF_WORD, 32'h0);
      chk(rd, {22'h0, w[1]}, "word_reg");
   endtask : t_deser
   task automatic close_out;
      if (err_total == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc > 5000) begin
         err_total++;
         close_out;
      end
   end
   initial begin
      {resetn, sig, ppm, fr, fd} = 5'h0;
      ce = 1'b1;
      req = '0;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      t_reset;
      t_auto;
      t_freeze;
      t_pipe;
      t_manual;
      t_deser;
      close_out;
   end
endmodule : cdl_rx_front_tb
